// File: core/mrsm_top.sv
// Purpose: MII receive pins and station management port with pin sharing
// Assumes: Pin selects are static configuration loaded from EEPROM offset 0x02
// Notes: All pin inputs pass two flip-flops; the receive clock is sampled, not used as a clock
//
// Functional notes
// - Device drives the management clock and times every management transfer from it.
// - Management data bits in both directions align to the management clock rising edge.
// - Management clock runs just under 1.5 MHz: 42-cycle half period at 125 MHz, about 1488 kHz.
// - Management frames follow the standard preamble, start, op, address, turnaround, data order.
// - Management data pin is bidirectional: device sends and receives on it.
// - Port-1 pin select chooses management clock/data or port-1 bits 0 and 1.
// - Receive valid marks valid data; data is ignored while valid is low.
// - Port-2 pin select chooses receive pins or port-2 general bits.
`timescale 1ns/1ps
`include "mrsm_defs.svh"

module mrsm_top #(
    parameter int MDC_HALF_CYC = `MRSM_MDC_HALF_CYC
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // Pin select configuration
    input  wire logic i_port1_pin_select,
    input  wire logic i_port2_pin_select,
    // Management request port
    input  wire logic i_mgmt_start,
    input  mrsm_pkg::mrsm_mgmt_req_t i_mgmt_req,
    output logic o_mgmt_busy,
    output logic o_mgmt_done,
    output logic [15:0] o_mgmt_rdata,
    // Port 1 general purpose side
    input  wire logic [1:0] i_port1_gpio_out,
    input  wire logic [1:0] i_port1_gpio_oe,
    output logic [1:0] o_port1_gpio_in,
    // Port 1 pins: bit0 management clock, bit1 management data
    input  wire logic i_port1_bit0,
    output logic o_port1_bit0,
    output logic o_port1_bit0_oe,
    input  wire logic i_port1_bit1,
    output logic o_port1_bit1,
    output logic o_port1_bit1_oe,
    // Port 2 pins: bit0 receive clock, bits 1-4 receive nibble, bit5 valid
    input  wire logic [5:0] i_port2_pins,
    input  wire logic i_rx_error_pin,
    output logic [5:0] o_port2_gpio_in,
    // Receive byte stream
    output mrsm_pkg::mrsm_rx_byte_t o_rx_byte,
    output logic o_rx_byte_valid,
    output logic o_rx_frame_active,
    output logic o_rx_frame_end,
    output logic o_rx_odd_nibble
);
    import mrsm_pkg::*;

    logic [1:0] p1_s1_r;
    logic [1:0] p1_s2_r;
    logic [6:0] p2_s1_r;
    logic [6:0] p2_s2_r;
    logic rxclk_d_r;
    logic rx_rise;
    logic mgmt_en;
    logic rx_en;
    logic eng_busy;
    logic eng_done;
    logic [15:0] eng_rdata;
    logic eng_mdc;
    logic eng_mdio;
    logic eng_mdio_oe;
    logic dv_d_r;
    logic half_r;
    logic [3:0] low_nib_r;
    logic low_err_r;

    assign mgmt_en = (i_port1_pin_select == `MRSM_PSEL_MII);
    assign rx_en = (i_port2_pin_select == `MRSM_PSEL_MII);

    // Two-stage synchronisers for every pin input; first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            p1_s1_r <= 2'h0;
            p1_s2_r <= 2'h0;
            p2_s1_r <= 7'h00;
            p2_s2_r <= 7'h00;
        end
        else
        begin
            p1_s1_r <= {i_port1_bit1, i_port1_bit0};
            p1_s2_r <= p1_s1_r;
            p2_s1_r <= {i_rx_error_pin, i_port2_pins};
            p2_s2_r <= p2_s1_r;
        end
    end

    // Receive clock edge finder on the synchronised copy
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            rxclk_d_r <= 1'b0;
        else
            rxclk_d_r <= p2_s2_r[`MRSM_P2_RXCLK];
    end

    // Data and clock share the same synchroniser depth, so the sample lines up with the edge
    assign rx_rise = rx_en && p2_s2_r[`MRSM_P2_RXCLK] && !rxclk_d_r;

    // Management engine; requests are taken only when port 1 carries management
    mrsm_mdio_master #(
        .HALF_CYC(MDC_HALF_CYC)
    ) u_master (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(i_mgmt_start && mgmt_en),
        .i_req(i_mgmt_req),
        .o_busy(eng_busy),
        .o_done(eng_done),
        .o_rdata(eng_rdata),
        .i_mdio_in(p1_s2_r[1]),
        .o_mdc(eng_mdc),
        .o_mdio_out(eng_mdio),
        .o_mdio_oe(eng_mdio_oe)
    );

    // Management status registered for the request side
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_mgmt_busy <= 1'b0;
            o_mgmt_done <= 1'b0;
            o_mgmt_rdata <= 16'h0000;
        end
        else
        begin
            o_mgmt_busy <= eng_busy;
            o_mgmt_done <= eng_done;
            if (eng_done)
                o_mgmt_rdata <= eng_rdata;
        end
    end

    // Port 1 pin mux; clock and data both pass one flop so they stay aligned
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_port1_bit0 <= 1'b0;
            o_port1_bit0_oe <= 1'b0;
            o_port1_bit1 <= 1'b0;
            o_port1_bit1_oe <= 1'b0;
            o_port1_gpio_in <= 2'h0;
        end
        else if (mgmt_en)
        begin
            o_port1_bit0 <= eng_mdc;
            o_port1_bit0_oe <= 1'b1;
            o_port1_bit1 <= eng_mdio;
            o_port1_bit1_oe <= eng_mdio_oe;
            o_port1_gpio_in <= 2'h0;
        end
        else
        begin
            o_port1_bit0 <= i_port1_gpio_out[0];
            o_port1_bit0_oe <= i_port1_gpio_oe[0];
            o_port1_bit1 <= i_port1_gpio_out[1];
            o_port1_bit1_oe <= i_port1_gpio_oe[1];
            o_port1_gpio_in <= p1_s2_r;
        end
    end

    // Port 2 general inputs, shown only when the pins are not used for receive
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_port2_gpio_in <= 6'h00;
        else
            o_port2_gpio_in <= rx_en ? 6'h00 : p2_s2_r[5:0];
    end

    // Nibble pairing: low nibble first; the nibble bus is ignored while valid is low
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            dv_d_r <= 1'b0;
            half_r <= 1'b0;
            low_nib_r <= 4'h0;
            low_err_r <= 1'b0;
            o_rx_byte <= '0;
            o_rx_byte_valid <= 1'b0;
            o_rx_frame_active <= 1'b0;
            o_rx_frame_end <= 1'b0;
            o_rx_odd_nibble <= 1'b0;
        end
        else
        begin
            o_rx_byte_valid <= 1'b0;
            o_rx_frame_end <= 1'b0;
            if (!rx_en)
            begin
                // Leaving receive mode abandons any frame in flight
                dv_d_r <= 1'b0;
                half_r <= 1'b0;
                o_rx_frame_active <= 1'b0;
            end
            else if (rx_rise)
            begin
                dv_d_r <= p2_s2_r[`MRSM_P2_DV];
                if (p2_s2_r[`MRSM_P2_DV])
                begin
                    o_rx_frame_active <= 1'b1;
                    o_rx_odd_nibble <= 1'b0;
                    if (!half_r)
                    begin
                        low_nib_r <= p2_s2_r[`MRSM_P2_NIBBLE_LSB +: 4];
                        low_err_r <= p2_s2_r[6];
                        half_r <= 1'b1;
                    end
                    else
                    begin
                        o_rx_byte.data <= {p2_s2_r[`MRSM_P2_NIBBLE_LSB +: 4], low_nib_r};
                        o_rx_byte.err <= low_err_r | p2_s2_r[6];
                        o_rx_byte_valid <= 1'b1;
                        half_r <= 1'b0;
                    end
                end
                else if (dv_d_r)
                begin
                    // Valid fell: close the frame, a dangling nibble is dropped and flagged
                    o_rx_frame_active <= 1'b0;
                    o_rx_frame_end <= 1'b1;
                    o_rx_odd_nibble <= half_r;
                    half_r <= 1'b0;
                end
            end
        end
    end

endmodule

// File: core/mrsm_defs.svh
// Purpose: Shared constants for the MII receive and station management block
// Assumes: 125 MHz system clock
// Notes: Times are kept in their own unit, and cycle counts are derived from them
`ifndef MRSM_DEFS_SVH
`define MRSM_DEFS_SVH

// Clock rates in kHz
`define MRSM_CLK_FREQ_KHZ 125000
`define MRSM_MDC_FREQ_KHZ 1500
// Half period of the management clock, rounded up so the clock never runs above its rate
`define MRSM_MDC_HALF_CYC ((`MRSM_CLK_FREQ_KHZ + 2 * `MRSM_MDC_FREQ_KHZ - 1) / (2 * `MRSM_MDC_FREQ_KHZ))

// Management frame layout, counted in bits from the first preamble bit
`define MRSM_FRAME_BITS 64
`define MRSM_PREAMBLE 32'hFFFFFFFF
`define MRSM_START 2'h1
`define MRSM_OP_WRITE 2'h1
`define MRSM_OP_READ 2'h2
`define MRSM_TA_WRITE 2'h2
`define MRSM_TA_FIRST_BIT 46
`define MRSM_DATA_FIRST_BIT 48

// Pin select encodings (configuration EEPROM offset 0x02)
`define MRSM_PSEL_EEPROM_OFFSET 8'h02
`define MRSM_PSEL_GPIO 1'b0
`define MRSM_PSEL_MII 1'b1

// Port 2 pin positions
`define MRSM_P2_RXCLK 0
`define MRSM_P2_NIBBLE_LSB 1
`define MRSM_P2_DV 5

`endif

// File: core/mrsm_pkg.sv
// Purpose: Types shared by the management master and the top level
// Assumes: mrsm_defs.svh holds all numeric constants
// Notes: Types only
package mrsm_pkg;

    // One management request
    typedef struct packed {
        logic        write;
        logic [4:0]  phy_addr;
        logic [4:0]  reg_addr;
        logic [15:0] wdata;
    } mrsm_mgmt_req_t;

    // One received byte
    typedef struct packed {
        logic [7:0] data;
        logic       err;
    } mrsm_rx_byte_t;

    // Management serial states
    typedef enum logic [1:0] {
        MS_IDLE,
        MS_LOW,
        MS_HIGH
    } mrsm_mgmt_state_t;

endpackage

// File: core/mrsm_mdio_master.sv
// Purpose: Serial engine for one management frame
// Assumes: i_mdio_in is already synchronised to i_clk
// Notes: Data changes at the clock fall so it is stable at the rise
`timescale 1ns/1ps
`include "mrsm_defs.svh"

module mrsm_mdio_master #(
    parameter int HALF_CYC = `MRSM_MDC_HALF_CYC
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // Request side
    input  wire logic i_start,
    input  mrsm_pkg::mrsm_mgmt_req_t i_req,
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_rdata,
    // Serial side
    input  wire logic i_mdio_in,
    output logic o_mdc,
    output logic o_mdio_out,
    output logic o_mdio_oe
);
    import mrsm_pkg::*;

    mrsm_mgmt_state_t state_r;
    logic [7:0] cnt_r;
    logic [5:0] bit_r;
    logic [63:0] shift_r;
    logic wr_r;
    logic tick;

    assign tick = (cnt_r == 8'(HALF_CYC - 1));
    assign o_busy = (state_r != MS_IDLE);

    // Half-period divider, held in idle so each frame starts aligned
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            cnt_r <= 8'h00;
        else if (state_r == MS_IDLE || tick)
            cnt_r <= 8'h00;
        else
            cnt_r <= cnt_r + 8'h01;
    end

    // Frame sequencing; the clock is made here, the only timing reference
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_r <= MS_IDLE;
            o_mdc <= 1'b0;
            o_done <= 1'b0;
            bit_r <= 6'h00;
            wr_r <= 1'b0;
            shift_r <= 64'h0;
            o_mdio_out <= 1'b0;
            o_mdio_oe <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            case (state_r)
                MS_IDLE:
                begin
                    o_mdc <= 1'b0;
                    o_mdio_oe <= 1'b0;
                    if (i_start)
                    begin
                        // Preamble, start, op, addresses, turnaround, data
                        shift_r <= {`MRSM_PREAMBLE, `MRSM_START,
                                    i_req.write ? `MRSM_OP_WRITE : `MRSM_OP_READ,
                                    i_req.phy_addr, i_req.reg_addr, `MRSM_TA_WRITE, i_req.wdata};
                        wr_r <= i_req.write;
                        bit_r <= 6'h00;
                        o_mdio_out <= 1'b1;
                        o_mdio_oe <= 1'b1;
                        state_r <= MS_LOW;
                    end
                end
                MS_LOW:
                    if (tick)
                    begin
                        o_mdc <= 1'b1;
                        state_r <= MS_HIGH;
                    end
                MS_HIGH:
                    if (tick)
                    begin
                        o_mdc <= 1'b0;
                        if (bit_r == 6'(`MRSM_FRAME_BITS - 1))
                        begin
                            state_r <= MS_IDLE;
                            o_mdio_oe <= 1'b0;
                            o_done <= 1'b1;
                        end
                        else
                        begin
                            // Next bit launched on the fall
                            bit_r <= bit_r + 6'h01;
                            shift_r <= {shift_r[62:0], 1'b0};
                            o_mdio_out <= shift_r[62];
                            // Release from turnaround on reads so the phy can drive
                            o_mdio_oe <= wr_r || (bit_r + 6'h01 < 6'(`MRSM_TA_FIRST_BIT));
                            state_r <= MS_LOW;
                        end
                    end
                default:
                    state_r <= MS_IDLE;
            endcase
        end
    end

    // Read data sampled at the rising edge
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_rdata <= 16'h0000;
        else if (state_r == MS_LOW && tick && !wr_r && bit_r >= 6'(`MRSM_DATA_FIRST_BIT))
            o_rdata <= {o_rdata[14:0], i_mdio_in};
    end

endmodule

// File: dv/mrsm_sva.sv
// Purpose: Port-level checks for mrsm_top
// Assumes: One clock domain, reset active high
// Notes: Frame and half period counts follow the parameter
`timescale 1ns/1ps
module mrsm_sva #(
    parameter int MDC_HALF_CYC = 42
) (
    // Clock, reset and selects
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_port1_pin_select,
    input wire logic i_port2_pin_select,
    // Management side
    input wire logic o_mgmt_busy,
    input wire logic o_mgmt_done,
    input wire logic [1:0] i_port1_gpio_oe,
    input wire logic o_port1_bit0,
    input wire logic o_port1_bit0_oe,
    input wire logic o_port1_bit1,
    input wire logic o_port1_bit1_oe,
    // Receive side
    input wire logic [5:0] o_port2_gpio_in,
    input wire logic o_rx_byte_valid,
    input wire logic o_rx_frame_active,
    input wire logic o_rx_frame_end
);
    localparam int FR = 128 * MDC_HALF_CYC;
    int hi_cnt;
    int busy_cnt;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // Cycles the management clock has been high
    always_ff @(posedge i_clk or posedge i_sys_rst)
        hi_cnt <= i_sys_rst ? 0 : (o_port1_bit0 ? hi_cnt + 1 : 0);
    // Cycles since busy rose, so the whole frame can be timed
    always_ff @(posedge i_clk or posedge i_sys_rst)
        busy_cnt <= i_sys_rst ? 0 : (o_mgmt_busy ? busy_cnt + 1 : 0);
    a_mdc_half_len: assert property (i_port1_pin_select && $fell(o_port1_bit0) |-> hi_cnt == MDC_HALF_CYC)
        else $error("clock high time wrong");
    a_mdc_in_frame: assert property (i_port1_pin_select && o_port1_bit0 |-> o_mgmt_busy)
        else $error("clock outside a frame");
    a_frame_len: assert property (o_mgmt_done |-> busy_cnt == FR)
        else $error("frame length wrong");
    a_data_at_rise: assert property (i_port1_pin_select && $rose(o_port1_bit0) |-> $stable(o_port1_bit1))
        else $error("data moved at clock rise");
    a_gpio_oe_pass: assert property (!i_port1_pin_select && $past(!i_port1_pin_select)
        |-> {o_port1_bit1_oe, o_port1_bit0_oe} == $past(i_port1_gpio_oe))
        else $error("port1 enables wrong");
    a_byte_gap: assert property (o_rx_byte_valid |=> !o_rx_byte_valid [*8])
        else $error("bytes too close");
    a_end_quiet: assert property (o_rx_frame_end |=> !o_rx_frame_end && !o_rx_frame_active)
        else $error("frame end not one pulse");
    a_p2_gpio_off: assert property (i_port2_pin_select && $past(i_port2_pin_select) |-> o_port2_gpio_in == 6'h00)
        else $error("port2 inputs seen in receive mode");
    a_p2_no_rx: assert property (!i_port2_pin_select && $past(!i_port2_pin_select) |-> !o_rx_byte_valid)
        else $error("byte in general purpose mode");
endmodule

// File: dv/mrsm_phy_model.sv
// Purpose: Behavioural phy on the management and receive pins
// Assumes: Management clock idles low; board pull-up on the data line
// Notes: Answers one address only; receive clock stands still between frames
`timescale 1ns/1ps
module mrsm_phy_model #(
    parameter logic [4:0] PHY_ADDR = 5'h05
) (
    // Management pins
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio = 1'b0,
    output logic o_mdio_oe = 1'b0,
    // Receive pins
    output logic [5:0] o_rx_pins = 6'h00,
    output logic o_rx_err = 1'b0
);
    logic [63:0] sh;
    logic [63:0] last_frame;
    logic [15:0] regs [32];
    logic [15:0] resp;
    int bit_n = 0;
    // Take each bit at the rise, change our own bit just after it
    always @(posedge i_mdc)
    begin
        sh = {sh[62:0], i_mdio};
        if (bit_n == 46 && sh[12:11] == 2'b10 && sh[10:6] == PHY_ADDR)
        begin
            resp = regs[sh[5:1]];
            o_mdio_oe = 1'b1;
            o_mdio = 1'b0;
        end
        else if (bit_n > 46 && bit_n < 63)
            o_mdio = resp[62 - bit_n];
        if (bit_n == 63)
        begin
            o_mdio_oe = 1'b0;
            last_frame = sh;
            if (sh[29:28] == 2'b01 && sh[27:23] == PHY_ADDR)
                regs[sh[22:18]] = sh[15:0];
        end
        bit_n = (bit_n + 1) % 64;
    end
    // One nibble per receive clock, bit 4 of each entry is the error flag
    task automatic rx_send(input logic [4:0] q[$]);
        #3;
        foreach (q[i])
        begin
            o_rx_pins[5:1] = {1'b1, q[i][3:0]};
            o_rx_err = q[i][4];
            #80 o_rx_pins[0] = 1'b1;
            #80 o_rx_pins[0] = 1'b0;
        end
        o_rx_pins[5:1] = {1'b0, ~o_rx_pins[4:1]};
        o_rx_err = 1'b0;
        #80 o_rx_pins[0] = 1'b1;
        #80 o_rx_pins[0] = 1'b0;
    endtask
endmodule

// File: dv/mii_receive_and_station_mgmt_tb.sv
// Purpose: Self-checking bench for mrsm_top
// Assumes: Half period shortened to 4 cycles
// Notes: Phy model hears the clock only in management mode
`timescale 1ns/1ps
module mii_receive_and_station_mgmt_tb;
    import mrsm_pkg::*;
    localparam int H = 4;
    localparam logic [4:0] PA = 5'h0A;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_port1_pin_select = 1'b0;
    logic i_port2_pin_select = 1'b0;
    logic i_mgmt_start = 1'b0;
    mrsm_mgmt_req_t i_mgmt_req = '0;
    logic [1:0] i_port1_gpio_out = 2'h0;
    logic [1:0] i_port1_gpio_oe = 2'h0;
    logic [1:0] ext1 = 2'h3;
    logic [5:0] ext2 = 6'h00;
    logic i_port1_bit0, i_port1_bit1, i_rx_error_pin, pm, pm_oe, mdc, odd;
    logic [5:0] i_port2_pins, prx;
    logic o_mgmt_busy, o_mgmt_done, o_port1_bit0, o_port1_bit0_oe, o_port1_bit1, o_port1_bit1_oe;
    logic [15:0] o_mgmt_rdata, wd, rd;
    logic [1:0] o_port1_gpio_in;
    logic [5:0] o_port2_gpio_in;
    mrsm_rx_byte_t o_rx_byte;
    logic o_rx_byte_valid, o_rx_frame_active, o_rx_frame_end, o_rx_odd_nibble;
    logic fe_d = 1'b0;
    logic [8:0] exp_q[$];
    logic [4:0] nq[$];
    logic [4:0] ra;
    int fails = 0;
    int ends = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 32'haee9;
    // Pin levels: an enabled driver wins, else pull-ups or the outside world
    assign i_port1_bit0 = o_port1_bit0_oe ? o_port1_bit0 : ext1[0];
    assign i_port1_bit1 = o_port1_bit1_oe ? o_port1_bit1 : (pm_oe ? pm : ext1[1]);
    assign mdc = i_port1_pin_select & o_port1_bit0_oe & o_port1_bit0;
    assign i_port2_pins = i_port2_pin_select ? prx : ext2;
    // System clock
    always #4 i_clk = ~i_clk;
    mrsm_top #(
        .MDC_HALF_CYC(H)
    ) DUT (
        .i_clk, .i_sys_rst, .i_port1_pin_select, .i_port2_pin_select, .i_mgmt_start, .i_mgmt_req,
        .o_mgmt_busy, .o_mgmt_done, .o_mgmt_rdata, .i_port1_gpio_out, .i_port1_gpio_oe, .o_port1_gpio_in,
        .i_port1_bit0, .o_port1_bit0, .o_port1_bit0_oe, .i_port1_bit1, .o_port1_bit1, .o_port1_bit1_oe,
        .i_port2_pins, .i_rx_error_pin, .o_port2_gpio_in, .o_rx_byte, .o_rx_byte_valid,
        .o_rx_frame_active, .o_rx_frame_end, .o_rx_odd_nibble
    );
    mrsm_phy_model #(
        .PHY_ADDR(PA)
    ) phy (
        .i_mdc(mdc), .i_mdio(i_port1_bit1), .o_mdio(pm), .o_mdio_oe(pm_oe),
        .o_rx_pins(prx), .o_rx_err(i_rx_error_pin)
    );
    task automatic give_verdict();
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp_m(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_r(input logic [8:0] got, input logic [8:0] exp, input string what);
        cmp_m({55'h0, got}, {55'h0, exp}, what);
    endtask
    function automatic logic [63:0] frame(input logic [1:0] op, input logic [4:0] pa, input logic [1:0] ta,
        input logic [15:0] d);
        return {32'hFFFFFFFF, 2'b01, op, pa, ra, ta, d};
    endfunction
    // One management frame to register ra; read data lands in rd
    task automatic mgmt(input logic w, input logic [4:0] pa, input logic [15:0] d);
        int n;
        i_mgmt_start <= 1'b1;
        i_mgmt_req <= '{w, pa, ra, d};
        @(posedge i_clk);
        i_mgmt_start <= 1'b0;
        n = 0;
        while (o_mgmt_done !== 1'b1 && n < 2000)
        begin
            @(posedge i_clk);
            n++;
        end
        // A frame that never finishes is a mismatch of its own
        cmp_m(64'(n >= 2000), 64'h0, "no frame end");
        rd = o_mgmt_rdata;
        repeat (2) @(posedge i_clk);
    endtask
    // Hang guard and the two-driver watch on the data line
    always @(posedge i_clk)
    begin
        cycles++;
        if (o_port1_bit1_oe === 1'b1 && pm_oe === 1'b1)
            cmp_m(64'h1, 64'h0, "data line driven twice");
        if (cycles == 20000)
        begin
            fails++;
            give_verdict();
        end
    end
    // Receive results against the queue model
    always @(posedge i_clk)
    begin
        if (o_rx_byte_valid === 1'b1)
        begin
            cmp_r(o_rx_byte, exp_q.size() ? exp_q.pop_front() : 9'h1FF, "rx byte");
            cmp_r({8'h00, o_rx_frame_active}, 9'h001, "frame active");
        end
        if (o_rx_frame_end === 1'b1)
            ends++;
        if (fe_d)
            cmp_r({8'h00, o_rx_odd_nibble}, {8'h00, odd}, "odd nibble");
        fe_d = (o_rx_frame_end === 1'b1);
    end
    // Main sequence
    initial
    begin
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        // Port 1 general purpose; a request here must be refused
        repeat (4)
        begin
            @(posedge i_clk);
            ext1 <= 2'($random(seed));
            i_port1_gpio_out <= 2'($random(seed));
            i_port1_gpio_oe <= 2'($random(seed));
            i_mgmt_start <= 1'b1;
            repeat (5) @(posedge i_clk);
            // Driven bits read back what we drive, the rest read the outside world
            cmp_m(o_port1_gpio_in, 2'((i_port1_gpio_oe & i_port1_gpio_out) | (~i_port1_gpio_oe & ext1)), "port1 pins");
            cmp_m(o_mgmt_busy, 1'b0, "refused start");
        end
        i_mgmt_start <= 1'b0;
        i_port1_gpio_oe <= 2'h0;
        i_port1_gpio_out <= 2'h0;
        ext1 <= 2'h3;
        repeat (4) @(posedge i_clk);
        i_port1_pin_select <= 1'b1;
        repeat (4) @(posedge i_clk);
        // Write then read back, three random registers
        repeat (3)
        begin
            ra = 5'($random(seed));
            wd = 16'($random(seed));
            mgmt(1'b1, PA, wd);
            cmp_m(phy.last_frame, frame(2'b01, PA, 2'b10, wd), "write frame");
            mgmt(1'b0, PA, 16'h0000);
            cmp_m(phy.last_frame, frame(2'b10, PA, 2'b10, wd), "read frame");
            cmp_m(rd, wd, "read data");
        end
        // No phy at this address, so only the pull-up answers
        mgmt(1'b0, PA ^ 5'h01, 16'h0000);
        cmp_m(rd, 16'hFFFF, "absent phy");
        cmp_m(phy.last_frame, frame(2'b10, PA ^ 5'h01, 2'b11, 16'hFFFF), "absent frame");
        // Frames of four, five and six nibbles with random errors
        i_port2_pin_select <= 1'b1;
        for (int f = 4; f < 7; f++)
        begin
            nq.delete();
            repeat (f) nq.push_back(5'($random(seed)));
            for (int k = 0; k + 1 < f; k += 2)
                exp_q.push_back({nq[k + 1][3:0], nq[k][3:0], nq[k][4] | nq[k + 1][4]});
            odd = f[0];
            phy.rx_send(nq);
            repeat (12) @(posedge i_clk);
        end
        cmp_r(9'(exp_q.size()), 9'h000, "bytes missing");
        cmp_r(9'(ends), 9'h003, "frame ends");
        // Port 2 back to general purpose
        i_port2_pin_select <= 1'b0;
        repeat (3)
        begin
            @(posedge i_clk);
            ext2 <= 6'($random(seed));
            repeat (5) @(posedge i_clk);
            cmp_r({3'h0, o_port2_gpio_in}, {3'h0, ext2}, "port2 pins");
        end
        give_verdict();
    end
endmodule
bind mrsm_top mrsm_sva #(.MDC_HALF_CYC(MDC_HALF_CYC)) u_sva (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_port1_pin_select(i_port1_pin_select),
    .i_port2_pin_select(i_port2_pin_select),
    .o_mgmt_busy(o_mgmt_busy),
    .o_mgmt_done(o_mgmt_done),
    .i_port1_gpio_oe(i_port1_gpio_oe),
    .o_port1_bit0(o_port1_bit0),
    .o_port1_bit0_oe(o_port1_bit0_oe),
    .o_port1_bit1(o_port1_bit1),
    .o_port1_bit1_oe(o_port1_bit1_oe),
    .o_port2_gpio_in(o_port2_gpio_in),
    .o_rx_byte_valid(o_rx_byte_valid),
    .o_rx_frame_active(o_rx_frame_active),
    .o_rx_frame_end(o_rx_frame_end)
);
